// *** common/lct_pkg.sv ***
// Package: register map, field positions and timing constants of the cycle timer
package lct_pkg;
    // Register offsets
    localparam logic [7:0] REG_FUNCTION_ENABLES = 8'h80;
    localparam logic [7:0] REG_INTEGRATION_LENGTH = 8'h81;
    localparam logic [7:0] REG_IDLE_LENGTH = 8'h83;
    localparam logic [7:0] REG_CONFIG0 = 8'h8d;
    // Reset values
    localparam logic [7:0] RST_FUNCTION_ENABLES = 8'h00;
    localparam logic [7:0] RST_INTEGRATION_LENGTH = 8'h00;
    localparam logic [7:0] RST_IDLE_LENGTH = 8'h00;
    localparam logic [7:0] RST_CONFIG0 = 8'h80;
    // Field positions
    localparam int BIT_OSC_ON = 0;
    localparam int BIT_MEAS_EN = 1;
    localparam int BIT_IDLE_EN = 3;
    localparam int BIT_STRETCH = 2;
    // Writable bit masks; other bits are reserved and kept as written
    localparam logic [7:0] MASK_ALL = 8'hff;
    // Timing: tick period in picoseconds and clock period in picoseconds
    localparam longint TICK_PS = 64'd2780000000;
    localparam longint CLK_PS = 64'd5000;
    localparam longint TICK_CYC = TICK_PS / CLK_PS;
    // Stretch factor for the idle tick
    localparam int STRETCH_MUL = 12;
    // Auto-zero duration in ticks (one tick)
    localparam logic [7:0] ZERO_TICKS = 8'h00;
    // Saturation: result grows by this step per tick, full scale cap
    localparam logic [16:0] RESULT_STEP = 17'h00400;
    localparam logic [16:0] RESULT_CAP = 17'h0ffff;
    localparam logic [7:0] TERM_COUNT = 8'h00;
    // Cycle states, Gray coded along off, zero, integrate, idle
    typedef enum logic [1:0]
    {
        ST_OFF = 2'b00,
        ST_ZERO = 2'b01,
        ST_INTEG = 2'b11,
        ST_IDLE = 2'b10
    } lct_state_t;
endpackage

// *** common/lct_tick_if.sv ***
// Interface: tick pacing between the cycle core and its divider
`timescale 1ns/1ps
interface lct_tick_if;
    logic run;     // Measurement on, with the oscillator bit also set
    logic tick;    // Base tick pulse
    logic stretch; // Stretch mode select
    logic idleTick; // Idle tick pulse, stretched or not
    modport core (output run, output stretch, input tick, input idleTick);
    modport div (input run, input stretch, output tick, output idleTick);
endinterface

// *** tb/lct_cycle_sva.sv ***
// Checker: port relations of the measurement-cycle timer
`timescale 1ns/1ps
module lct_cycle_sva
    import lct_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYC
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic oscRun,
    input wire logic integrating,
    input wire logic zeroing,
    input wire logic idling,
    input wire logic integDone,
    input wire logic [15:0] result
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] enShadow_ff; // Enable byte as last written
    logic [31:0] integCnt_ff; // Length of the running integration
    // Shadow the enable byte and time each integration run; the end pulse
    // restarts the count, since runs follow back to back without idle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            enShadow_ff <= 8'h00;
            integCnt_ff <= 32'h00000000;
        end
        else
        begin
            if (regWrEn && regAddr == REG_FUNCTION_ENABLES)
                enShadow_ff <= regWrData;
            if (integrating && !integDone)
                integCnt_ff <= integCnt_ff + 32'h00000001;
            else
                integCnt_ff <= 32'h00000000;
        end
    end
    sequence s_en_write;
        regWrEn && regAddr == REG_FUNCTION_ENABLES;
    endsequence
    a_osc_follows_write: assert property (s_en_write |=>
        oscRun == enShadow_ff[BIT_OSC_ON])
        else $error("oscillator bit not taken from write");
    a_unpowered_quiet: assert property (!oscRun && !$past(oscRun) |->
        !(integrating || zeroing || idling))
        else $error("cycle active without oscillator");
    // Enables are judged only once the write has settled
    a_meas_needs_bits: assert property (integrating &&
        $stable(enShadow_ff) |->
        enShadow_ff[BIT_MEAS_EN] && enShadow_ff[BIT_OSC_ON])
        else $error("integration without both enable bits");
    a_idle_needs_en: assert property (idling &&
        $stable(enShadow_ff) |-> enShadow_ff[BIT_IDLE_EN])
        else $error("idle interval with idle enable clear");
    a_done_one_cycle: assert property (integDone |=> !integDone)
        else $error("end pulse longer than one cycle");
    a_done_after_integ: assert property ($rose(integDone) |->
        $past(integrating))
        else $error("end pulse without integration");
    a_integ_bounded: assert property (
        integCnt_ff <= 256 * TICK_CYCLES)
        else $error("integration longer than 256 ticks");
    a_result_on_done: assert property ($changed(result) |-> integDone)
        else $error("result moved without end pulse");
    a_one_state: assert property (
        $onehot0({integrating, zeroing, idling}))
        else $error("more than one cycle state");
endmodule
bind light_cycle_timing_control lct_cycle_sva
    #(.TICK_CYCLES(TICK_CYCLES)) chk_u
(
    .mclk(mclk),
    .sys_rst(sys_rst),
    .regWrEn(regWrEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .oscRun(oscRun),
    .integrating(integrating),
    .zeroing(zeroing),
    .idling(idling),
    .integDone(integDone),
    .result(result)
);

// *** tb/light_cycle_timing_control_tb_top.sv ***
// Testbench: register access and cycle timing of the cycle timer
`timescale 1ns/1ps
module light_cycle_timing_control_tb_top;
    import lct_pkg::*;
    localparam longint TK = 10; // Short tick keeps the run brief
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [16:0] rawResult = 17'h00000;
    logic oscRun, integrating, zeroing, idling, integDone;
    logic [15:0] result;
    int err_count = 0;
    int num_checks = 0;
    light_cycle_timing_control #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk),
        .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .rawResult(rawResult), .oscRun(oscRun), .integrating(integrating),
        .zeroing(zeroing), .idling(idling), .integDone(integDone),
        .result(result));
    always #2.5 mclk = ~mclk;
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge mclk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
        @(negedge mclk);
        chk("read data", {8'h00, exp}, {8'h00, regRdData});
    endtask
    // Reset values, then storage in the two length fields and the enable byte, and an ignored unmapped write
    task automatic t_regs();
        rd(REG_FUNCTION_ENABLES, 8'h00);
        rd(REG_INTEGRATION_LENGTH, 8'h00);
        rd(REG_IDLE_LENGTH, 8'h00);
        rd(REG_CONFIG0, 8'h80);
        wr(8'h82, 8'h5a);
        rd(8'h82, 8'h00);
        wr(REG_INTEGRATION_LENGTH, 8'ha5);
        wr(REG_IDLE_LENGTH, 8'h5a);
        wr(REG_FUNCTION_ENABLES, 8'hf4);
        rd(REG_INTEGRATION_LENGTH, 8'ha5);
        rd(REG_IDLE_LENGTH, 8'h5a);
        rd(REG_FUNCTION_ENABLES, 8'hf4);
        chk("osc off", 16'h0000, {15'h0000, oscRun});
        wr(REG_FUNCTION_ENABLES, 8'h00);
    endtask
    // One measurement cycle: zeroing, integration, result, idle or restart
    task automatic t_cycle(logic [7:0] len, logic ie, logic [7:0] il,
                           logic st, logic sp, logic [16:0] raw);
        int n;
        bit sawZ;
        bit sawD;
        longint cap;
        longint expIdle;
        n = 0;
        sawZ = 0;
        sawD = 0;
        cap = 1024 * (len + 1) - 1;
        cap = (cap > 65535) ? 65535 : cap;
        cap = (raw < cap) ? raw : cap;
        wr(REG_INTEGRATION_LENGTH, len);
        // Converter count changes on a rising edge, as the design expects
        rawResult <= raw;
        wr(REG_IDLE_LENGTH, il);
        wr(REG_CONFIG0, st ? 8'h84 : 8'h80);
        if (sp)
            wr(REG_FUNCTION_ENABLES, 8'h01);
        wr(REG_FUNCTION_ENABLES, {4'h0, ie, 3'b011});
        while (!integrating && n < 8 * TK)
        begin
            @(negedge mclk);
            sawZ |= zeroing;
            n++;
        end
        chk("oscillator", 16'h0001, {15'h0000, oscRun});
        chk("zeroing seen", {15'h0000, !sp}, {15'h0000, sawZ});
        n = 0;
        // Without idle the runs follow back to back, so the end is the pulse
        while (!integDone && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        chk("integ cycles", 16'((len + 1) * TK), 16'(n));
        repeat (3)
        begin
            if (integDone === 1'b1)
                sawD = 1;
            if (!sawD)
                @(negedge mclk);
        end
        chk("end pulse", 16'h0001, {15'h0000, sawD});
        chk("result", 16'(cap), result);
        repeat (2) if (!idling && !integrating) @(negedge mclk);
        chk("idle", {15'h0000, ie}, {15'h0000, idling});
        n = 0;
        while (idling && n < 40000)
        begin
            @(negedge mclk);
            n++;
        end
        expIdle = (il + 1) * TK * (st ? 12 : 1);
        if (ie)
            chk("idle cycles", 16'(expIdle), 16'(n));
        repeat (2) if (!integrating) @(negedge mclk);
        chk("restart", 16'h0001, {15'h0000, integrating});
        wr(REG_FUNCTION_ENABLES, 8'h00);
        // The cycle is abandoned one clock after the write lands
        repeat (2) @(negedge mclk);
        chk("stop", 16'h0000, {15'h0000, oscRun | integrating});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog cuts a hang well above the expected run time
    initial
    begin
        repeat (90000) @(posedge mclk);
        err_count++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_cycle(8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 17'h1ffff);
        t_cycle(8'h01, 1'b1, 8'h01, 1'b0, 1'b1, 17'h00500);
        t_cycle(8'h40, 1'b1, 8'h00, 1'b1, 1'b0, 17'h1ffff);
        t_cycle(8'hff, 1'b1, 8'hff, 1'b0, 1'b0, 17'h12345);
        complete_run();
    end
endmodule

// *** verilog/lct_tick_div.sv ***
// Tick divider: base tick and stretched idle tick from the system clock
`timescale 1ns/1ps
module lct_tick_div
    import lct_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYC
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    lct_tick_if.div tk
);
    // Counter width covers the default tick with margin
    localparam int CW = 32;
    initial
    begin
        if (TICK_CYCLES < 2 || TICK_CYCLES >= 64'h100000000)
            $error("lct_tick_div: TICK_CYCLES out of range");
    end
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
    localparam logic [3:0] MUL_LAST = 4'(STRETCH_MUL - 1);

    logic [CW-1:0] cnt_ff; // Cycles within a tick
    logic [3:0] mul_ff;    // Ticks within a stretched tick
    logic tick_ff;
    logic idle_ff;
    wire wrap = (cnt_ff == LAST);
    wire mulWrap = (mul_ff == MUL_LAST);

    // Measurement off, or a stopped oscillator, holds the divider at zero so a new run is aligned
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !tk.run)
        begin
            cnt_ff <= '0;
            mul_ff <= '0;
            tick_ff <= 1'b0;
            idle_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= wrap ? '0 : cnt_ff + 1'b1; // R08
            tick_ff <= wrap;
            // Stretch phase restarts with each wait so every wait tick is whole
            if (!tk.stretch)
                mul_ff <= '0;
            else if (wrap)
                mul_ff <= mulWrap ? '0 : mul_ff + 1'b1; // R13
            idle_ff <= wrap && (!tk.stretch || mulWrap); // R13
        end
    end
    assign tk.tick = tick_ff;
    assign tk.idleTick = idle_ff;
endmodule

// *** verilog/light_cycle_timing_control.sv ***
// Measurement-cycle control: enables, integration and idle down counters
`timescale 1ns/1ps
// Summary of operation
// R01: Enable bit 0 runs the oscillator
// R02: Enable bit 1 turns measurement on
// R03: Measurement needs oscillator bit set too
// R04: Both bits set together run auto-zero first
// R05: Host programs fields before measurement enable
// R06: Enable bit 3 inserts idle interval
// R07: Integration length is 8-bit field
// R08: Timers advance on 2.78 ms tick
// R09: Integration down counter ends at zero
// R10: Integration lasts field plus one ticks
// R11: Idle down counter ends at zero
// R12: Idle lasts field plus one ticks
// R13: Stretch bit makes idle tick twelvefold
// R14: Result saturates, cap grows per tick
module light_cycle_timing_control
    import lct_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYC
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic [16:0] rawResult,
    output logic oscRun,
    output logic integrating,
    output logic zeroing,
    output logic idling,
    output logic integDone,
    output logic [15:0] result
);
    import lct_pkg::*;

    // Register state
    logic [7:0] enables_ff;   // Function enables
    logic [7:0] integLen_ff;  // Integration length
    logic [7:0] idleLen_ff;   // Idle length
    logic [7:0] config0_ff;   // Holds the stretch bit
    logic [7:0] rdData_ff;
    // Cycle state
    lct_state_t state_ff;
    lct_state_t nxt_state;
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic [8:0] ticks_ff;     // Ticks spent integrating, for the cap
    logic zeroPending_ff;     // Auto-zero owed before first measurement
    logic done_ff;
    logic [15:0] result_ff;
    // State flags kept as flops so the outputs carry no decode glitches
    logic stInteg_ff;
    logic stZero_ff;
    logic stIdle_ff;

    // Tick divider
    lct_tick_if tk ();
    lct_tick_div #(.TICK_CYCLES(TICK_CYCLES)) uDiv
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tk(tk)
    );

    // Decodes
    wire wrEnables = regWrEn && (regAddr == REG_FUNCTION_ENABLES);
    wire wrIntegLen = regWrEn && (regAddr == REG_INTEGRATION_LENGTH);
    wire wrIdleLen = regWrEn && (regAddr == REG_IDLE_LENGTH);
    wire wrConfig0 = regWrEn && (regAddr == REG_CONFIG0);
    wire oscOn = enables_ff[BIT_OSC_ON];
    // Measurement only counts with the oscillator also on
    wire measOn = enables_ff[BIT_MEAS_EN] && oscOn; // R03
    wire idleOn = enables_ff[BIT_IDLE_EN];
    // Both bits rising in one write owes an auto-zero pass
    // A write that finds either bit already set does not count as both rising
    wire bothRise = wrEnables && regWrData[BIT_OSC_ON]
        && regWrData[BIT_MEAS_EN] && !oscOn
        && !enables_ff[BIT_MEAS_EN]; // R04
    wire atTerm = (count_ff == TERM_COUNT);
    wire integEnd = (state_ff == ST_INTEG) && tk.tick && atTerm; // R09
    // Cap is 1024 per tick less one, up to full scale; the count includes
    // the terminating tick, and the wide sum keeps long runs from wrapping
    wire [8:0] ticksEnd = ticks_ff + 9'h001;
    wire [18:0] capWide = {ticksEnd, 10'h000} - 19'h00001;
    wire [16:0] capEnd = (capWide > {2'b00, RESULT_CAP}) ? RESULT_CAP
        : capWide[16:0];
    wire [16:0] limitedEnd = (rawResult > capEnd) ? capEnd : rawResult; // R14

    // Divider is paced only while a cycle is wanted, so every integration not begun by
    // clearing the idle enable starts on a tick boundary; this needs the oscillator bit as well
    assign tk.run = measOn; // R01
    // Stretch only counts inside a wait, so the prescale starts aligned
    assign tk.stretch = config0_ff[BIT_STRETCH]
        && (state_ff == ST_IDLE); // R13

    // Read multiplexer; unmapped addresses read zero
    wire [7:0] rdMux =
        (regAddr == REG_FUNCTION_ENABLES) ? enables_ff :
        (regAddr == REG_INTEGRATION_LENGTH) ? integLen_ff :
        (regAddr == REG_IDLE_LENGTH) ? idleLen_ff :
        (regAddr == REG_CONFIG0) ? config0_ff : 8'h00;

    // Register writes; host is expected to set fields before enabling
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            enables_ff <= RST_FUNCTION_ENABLES;
            integLen_ff <= RST_INTEGRATION_LENGTH;
            idleLen_ff <= RST_IDLE_LENGTH;
            config0_ff <= RST_CONFIG0;
            rdData_ff <= 8'h00;
        end
        else
        begin
            if (wrEnables)
                enables_ff <= regWrData & MASK_ALL; // R01 R02 R06
            if (wrIntegLen)
                integLen_ff <= regWrData; // R07
            if (wrIdleLen)
                idleLen_ff <= regWrData;
            if (wrConfig0)
                config0_ff <= regWrData;
            if (regRdEn)
                rdData_ff <= rdMux;
        end
    end

    // Next-state logic of the measurement cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        case (state_ff)
            ST_OFF:
            begin
                if (measOn) // R02
                begin
                    nxt_state = zeroPending_ff ? ST_ZERO : ST_INTEG;
                    nxt_count = zeroPending_ff ? ZERO_TICKS : integLen_ff;
                end
            end
            ST_ZERO:
            begin
                if (tk.tick)
                begin
                    nxt_state = ST_INTEG;
                    nxt_count = integLen_ff;
                end
            end
            ST_INTEG:
            begin
                if (tk.tick)
                begin
                    if (atTerm && idleOn) // R06
                    begin
                        nxt_state = ST_IDLE;
                        nxt_count = idleLen_ff; // R11
                    end
                    else if (atTerm)
                        nxt_count = integLen_ff; // R10
                    else
                        nxt_count = count_ff - 8'h01; // R09
                end
            end
            ST_IDLE:
            begin
                // Clearing the idle enable ends the wait at once
                if (!idleOn) // R06
                begin
                    nxt_state = ST_INTEG;
                    nxt_count = integLen_ff;
                end
                else if (tk.idleTick) // R13
                begin
                    if (atTerm) // R11
                    begin
                        nxt_state = ST_INTEG;
                        nxt_count = integLen_ff;
                    end
                    else
                        nxt_count = count_ff - 8'h01; // R12
                end
            end
            default:
            begin
                nxt_state = ST_OFF;
                nxt_count = TERM_COUNT;
            end
        endcase
        // Dropping either enable abandons the cycle at once
        if (!measOn)
        begin
            nxt_state = ST_OFF;
            nxt_count = TERM_COUNT;
        end
    end

    // Cycle registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_OFF;
            count_ff <= TERM_COUNT;
            ticks_ff <= 9'h000;
            zeroPending_ff <= 1'b0;
            done_ff <= 1'b0;
            result_ff <= 16'h0000;
            stInteg_ff <= 1'b0;
            stZero_ff <= 1'b0;
            stIdle_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            done_ff <= integEnd;
            stInteg_ff <= (nxt_state == ST_INTEG);
            stZero_ff <= (nxt_state == ST_ZERO);
            stIdle_ff <= (nxt_state == ST_IDLE);
            // Set wins: a fresh request survives the zero pass finishing
            if (bothRise)
                zeroPending_ff <= 1'b1; // R04
            else if (state_ff == ST_ZERO && tk.tick)
                zeroPending_ff <= 1'b0;
            if (state_ff != ST_INTEG)
                ticks_ff <= 9'h000;
            else if (integEnd)
                ticks_ff <= 9'h000;
            else if (tk.tick)
                ticks_ff <= ticks_ff + 9'h001;
            // Result captured as integration ends, including final tick
            if (integEnd)
                result_ff <= 16'(limitedEnd); // R14
        end
    end

    // Outputs straight from flip-flops
    assign regRdData = rdData_ff;
    assign oscRun = enables_ff[BIT_OSC_ON];
    assign integrating = stInteg_ff;
    assign zeroing = stZero_ff;
    assign idling = stIdle_ff;
    assign integDone = done_ff;
    assign result = result_ff;
endmodule
